// file: rtl/cmw_host_ctrl.sv
// cmw_host_ctrl: controller end; apb registers for mode orders and status, transmit gating.
// assumes ctl_tx comes from a protocol controller on pclk; apb on pclk.
`timescale 1ns/1ns
`default_nettype none
module cmw_host_ctrl
	import cmw_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// protocol controller
	input wire logic ctl_tx,
	output logic ctl_rx,
	// transceiver side
	cmw_link_if.host lk
);
	typedef struct packed {
		cmw_mode_e mode_req;
		logic wdog;
		logic supply;
		logic mode_wr;
		logic clr_wake;
		logic clr_fail;
		logic clr_int;
		logic [CNT_W-1:0] hold_cnt;
		logic tx_q;
		logic rx_q;
		logic [31:0] rdata;
	} cmw_host_s;

	localparam cmw_host_s RST = '{
		mode_req: CMW_OFF, wdog: 1'b0, supply: 1'b0, mode_wr: 1'b0, clr_wake: 1'b0,
		clr_fail: 1'b0, clr_int: 1'b0, hold_cnt: '0, tx_q: 1'b1, rx_q: 1'b1, rdata: '0};

	cmw_host_s s;
	cmw_host_s next_s;
	logic acc;
	logic mapped;
	logic refuse;

	assign acc = psel && penable;
	assign mapped = (paddr == REG_CTRL) || (paddr == REG_CMD) || (paddr == REG_STATUS);
	// normal mode is not ordered before the supply is on
	assign refuse = pwrite && (paddr == REG_CMD) && pwdata[CMD_APPLY_BIT] &&
		(s.mode_req == CMW_NORMAL) && !s.supply;

	always_comb begin
		next_s = s;
		next_s.mode_wr = 1'b0;
		next_s.clr_wake = 1'b0;
		next_s.clr_fail = 1'b0;
		next_s.clr_int = 1'b0;
		next_s.rx_q = lk.rx_data_out;
		if (psel && !penable) begin
			case (paddr)
				REG_CTRL: next_s.rdata = {28'h000_0000, s.supply, s.wdog, s.mode_req};
				REG_STATUS: next_s.rdata = {25'h000_0000, lk.transceiver_supply, lk.int_n,
					lk.rx_data_out, lk.mode_now, lk.bus_fail_flag, lk.bus_wake_flag};
				default: next_s.rdata = 32'h0000_0000;
			endcase
		end
		if (acc && pwrite && !refuse) begin
			case (paddr)
				REG_CTRL: begin
					next_s.mode_req = cmw_mode_e'(pwdata[CTRL_MODE_LSB +: 2]);
					next_s.wdog = pwdata[CTRL_WDOG_BIT];
					next_s.supply = pwdata[CTRL_SUPPLY_BIT];
				end
				REG_CMD: begin
					next_s.mode_wr = pwdata[CMD_APPLY_BIT];
					next_s.clr_wake = pwdata[CMD_CLR_WAKE_BIT];
					next_s.clr_fail = pwdata[CMD_CLR_FAIL_BIT];
					next_s.clr_int = pwdata[CMD_CLR_INT_BIT];
					if (pwdata[CMD_APPLY_BIT] && s.mode_req == CMW_NORMAL) begin
						next_s.hold_cnt = CNT_W'(HOLD_CYC);
					end
				end
				default: next_s.mode_wr = 1'b0;
			endcase
		end else if (s.hold_cnt != '0) begin
			next_s.hold_cnt = s.hold_cnt - 1'b1;
		end
		// recessive until the transceiver has finished enabling
		next_s.tx_q = (next_s.hold_cnt != '0) ? 1'b1 : ctl_tx;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= RST;
		end else begin
			s <= next_s;
		end
	end

	assign pready = 1'b1;
	assign pslverr = acc && (!mapped || refuse);
	assign prdata = s.rdata;
	assign ctl_rx = s.rx_q;
	assign lk.tx_data_in = s.tx_q;
	assign lk.mode_req = s.mode_req;
	assign lk.mode_wr = s.mode_wr;
	assign lk.wdog_on_bus_wake = s.wdog;
	// supply kept off while the transceiver is wake-capable
	assign lk.transceiver_supply = s.supply && (lk.mode_now != CMW_WAKE);
	assign lk.clr_wake = s.clr_wake;
	assign lk.clr_fail = s.clr_fail;
	assign lk.clr_int = s.clr_int;
endmodule : cmw_host_ctrl
`default_nettype wire

// file: rtl/cmw_link_if.sv
// cmw_link_if: wires between the transceiver control and its protocol/host controller.
// assumes both ends run on the same pclk.
`timescale 1ns/1ns
`default_nettype none
interface cmw_link_if;
	import cmw_pkg::*;
	logic tx_data_in;
	logic rx_data_out;
	cmw_mode_e mode_req;
	logic mode_wr;
	cmw_mode_e mode_now;
	logic wdog_on_bus_wake;
	logic transceiver_supply;
	logic clr_wake;
	logic clr_fail;
	logic clr_int;
	logic bus_wake_flag;
	logic bus_fail_flag;
	logic int_n;

	modport dev (
		input tx_data_in, mode_req, mode_wr, wdog_on_bus_wake, transceiver_supply,
		input clr_wake, clr_fail, clr_int,
		output rx_data_out, mode_now, bus_wake_flag, bus_fail_flag, int_n
	);
	modport host (
		output tx_data_in, mode_req, mode_wr, wdog_on_bus_wake, transceiver_supply,
		output clr_wake, clr_fail, clr_int,
		input rx_data_out, mode_now, bus_wake_flag, bus_fail_flag, int_n
	);
endinterface : cmw_link_if
`default_nettype wire

// file: rtl/cmw_pkg.sv
// cmw_pkg: constants and types shared by the transceiver mode/wake control and its controller end.
// assumes a single 100 MHz clock on both ends.
package cmw_pkg;
	localparam int CLK_NS = 10;
	localparam int CNT_W = 18;

	// transceiver mode field, wake-capable reads 01
	typedef enum logic [1:0] {
		CMW_OFF = 2'h0,
		CMW_WAKE = 2'h1,
		CMW_RXONLY = 2'h2,
		CMW_NORMAL = 2'h3
	} cmw_mode_e;

	// operating mode of the surrounding system chip
	typedef enum logic [2:0] {
		CMW_CHIP_INIT = 3'h0,
		CMW_CHIP_NORMAL = 3'h1,
		CMW_CHIP_STOP = 3'h2,
		CMW_CHIP_SLEEP = 3'h3,
		CMW_CHIP_RESTART = 3'h4,
		CMW_CHIP_FAILSAFE = 3'h5
	} cmw_chip_e;

	// wake pattern detector, gray along the usual path
	typedef enum logic [1:0] {
		CMW_W_IDLE = 2'b00,
		CMW_W_DOM1 = 2'b01,
		CMW_W_REC = 2'b11,
		CMW_W_DOM2 = 2'b10
	} cmw_wk_e;

	// times in ns; least times round up, longest round down
	localparam int EN_TIME_NS = 20000;
	localparam int WAKE_MIN_NS = 500;
	localparam int WAKE_MAX_NS = 1800000;
	localparam int TXTO_NS = 1500000;
	localparam int EN_CYC = (EN_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int WAKE_MIN_CYC = (WAKE_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int WAKE_MAX_CYC = WAKE_MAX_NS / CLK_NS;
	localparam int TXTO_CYC = (TXTO_NS + CLK_NS - 1) / CLK_NS;
	// controller keeps the transmit line recessive a little past the enable time
	localparam int HOLD_CYC = EN_CYC + 2;

	// controller register map (apb byte addresses)
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_CMD = 12'h004;
	localparam logic [11:0] REG_STATUS = 12'h008;
	// ctrl fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_WDOG_BIT = 2;
	localparam int CTRL_SUPPLY_BIT = 3;
	// cmd fields, write one to act
	localparam int CMD_APPLY_BIT = 0;
	localparam int CMD_CLR_WAKE_BIT = 1;
	localparam int CMD_CLR_FAIL_BIT = 2;
	localparam int CMD_CLR_INT_BIT = 3;
	// status fields
	localparam int ST_WAKE_BIT = 0;
	localparam int ST_FAIL_BIT = 1;
	localparam int ST_MODE_LSB = 2;
	localparam int ST_RX_BIT = 4;
	localparam int ST_INTN_BIT = 5;
	localparam int ST_SUPPLY_BIT = 6;
	localparam logic [2:0] CTRL_RESET = 3'h0;
endpackage : cmw_pkg

// file: rtl/cmw_xcvr_ctrl.sv
// cmw_xcvr_ctrl: transceiver mode control, enable sequence, wake detection, dominant time-out.
// assumes chip_mode comes from logic on pclk; bus_rx_pin is asynchronous (low = dominant).
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - reset to off; off always allowed, ignores wake
// - normal only via write in chip normal
// - normal mode: bus follows transmit input
// - controller holds transmit recessive during enable
// - dominant during enable never driven
// - normal/receive-only: receive output shows bus
// - receive-only: driver off, chip normal/stop
// - wake-capable selectable; forced in fail-safe
// - wake drives receive low until mode change
// - wake pattern: dom, rec, dom within filters
// - mode field keeps wake-capable after wake
// - rearm by toggling mode away and back
// - rearm on entry to stop or fail-safe
// - software selects wake/off before sleep
// - wake in normal/stop: interrupt, flag, receive low
// - no automatic stop to normal after wake
// - wake in stop enables watchdog if optioned
// - wake in sleep requests restart, no interrupt
// - wake in restart/fail-safe requests restart
// - long dominant transmit disables driver, flags
// - driver returns when dominant ends
// - supply on before normal, off in wake
module cmw_xcvr_ctrl
	import cmw_pkg::*;
#(
	parameter int WAKE_MAX_P = WAKE_MAX_CYC,
	parameter int TXTO_P = TXTO_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// controller side
	cmw_link_if.dev lk,
	// bus side
	input wire logic bus_rx_pin,
	output logic bus_dom_drive,
	// system chip side
	input wire cmw_chip_e chip_mode,
	output logic chip_restart_req,
	output logic wdog_enable_req
);
	localparam logic [CNT_W-1:0] EN_C = CNT_W'(EN_CYC);
	localparam logic [CNT_W-1:0] WMIN_C = CNT_W'(WAKE_MIN_CYC);
	localparam logic [CNT_W-1:0] WMAX_C = CNT_W'(WAKE_MAX_P);
	localparam logic [CNT_W-1:0] TXTO_C = CNT_W'(TXTO_P);

	typedef struct packed {
		logic [1:0] rx_sync;
		cmw_mode_e mode;
		cmw_chip_e chip_q;
		logic armed;
		logic woke;
		logic [CNT_W-1:0] en_cnt;
		logic tx_ok;
		logic [CNT_W-1:0] to_cnt;
		logic to_act;
		cmw_wk_e wst;
		logic [CNT_W-1:0] ph_cnt;
		logic wake_flag;
		logic fail_flag;
		logic int_pend;
		logic restart_req;
		logic wdog_req;
		logic rx_out;
		logic drive;
	} cmw_dev_s;

	localparam cmw_dev_s RST = '{
		rx_sync: 2'h3, mode: CMW_OFF, chip_q: CMW_CHIP_INIT, armed: 1'b1, woke: 1'b0,
		en_cnt: '0, tx_ok: 1'b0, to_cnt: '0, to_act: 1'b0, wst: CMW_W_IDLE, ph_cnt: '0,
		wake_flag: 1'b0, fail_flag: 1'b0, int_pend: 1'b0, restart_req: 1'b0,
		wdog_req: 1'b0, rx_out: 1'b1, drive: 1'b0};

	cmw_dev_s s;
	cmw_dev_s next_s;

	// which transceiver modes each chip mode admits
	function automatic logic mode_allowed(input cmw_mode_e m, input cmw_chip_e c);
		case (m)
			CMW_OFF: mode_allowed = 1'b1;
			CMW_NORMAL: mode_allowed = (c == CMW_CHIP_NORMAL);
			CMW_RXONLY: mode_allowed = (c == CMW_CHIP_NORMAL) || (c == CMW_CHIP_STOP);
			CMW_WAKE: mode_allowed = (c == CMW_CHIP_STOP) || (c == CMW_CHIP_SLEEP) ||
				(c == CMW_CHIP_RESTART) || (c == CMW_CHIP_NORMAL);
			default: mode_allowed = 1'b0;
		endcase
	endfunction : mode_allowed

	always_comb begin
		logic bus_dom;
		logic wake_evt;
		logic ph_ok;
		next_s = s;
		bus_dom = ~s.rx_sync[1];
		wake_evt = 1'b0;
		// counter holds phase length minus one, so both limits stay strict on the length
		ph_ok = (s.ph_cnt >= WMIN_C) && (s.ph_cnt < WMAX_C - 1'b1);
		next_s.rx_sync = {s.rx_sync[0], bus_rx_pin};
		next_s.chip_q = chip_mode;
		next_s.restart_req = 1'b0;
		next_s.wdog_req = 1'b0;

		if (chip_mode != s.chip_q &&
			(chip_mode == CMW_CHIP_STOP || chip_mode == CMW_CHIP_FAILSAFE)) begin
			next_s.armed = 1'b1;
		end
		if (chip_mode == CMW_CHIP_FAILSAFE && s.mode != CMW_WAKE) begin
			next_s.mode = CMW_WAKE;
			next_s.woke = 1'b0;
		end else if (lk.mode_wr && mode_allowed(lk.mode_req, chip_mode)) begin
			if (lk.mode_req != s.mode) begin
				next_s.woke = 1'b0;
				if (s.mode == CMW_WAKE) begin
					next_s.armed = 1'b1;
				end
			end
			if (lk.mode_req == CMW_NORMAL && s.mode != CMW_NORMAL) begin
				next_s.en_cnt = '0;
				next_s.tx_ok = 1'b0;
			end
			next_s.mode = lk.mode_req;
		end

		// enable sequence: a dominant already present is swallowed
		if (s.mode == CMW_NORMAL) begin
			if (s.en_cnt != EN_C) begin
				next_s.en_cnt = s.en_cnt + 1'b1;
			end else if (lk.tx_data_in) begin
				next_s.tx_ok = 1'b1;
			end
		end

		// dominant time-out; mode field untouched so recovery is silent
		if (lk.tx_data_in || s.mode != CMW_NORMAL) begin
			next_s.to_cnt = '0;
			next_s.to_act = 1'b0;
		end else if (s.tx_ok) begin
			if (s.to_cnt != TXTO_C) begin
				next_s.to_cnt = s.to_cnt + 1'b1;
			end else begin
				next_s.to_act = 1'b1;
			end
		end

		// wake pattern detector, only while armed in wake-capable
		case (s.wst)
			CMW_W_IDLE: begin
				next_s.ph_cnt = '0;
				if (bus_dom) begin
					next_s.wst = CMW_W_DOM1;
				end
			end
			CMW_W_DOM1: begin
				if (bus_dom) begin
					next_s.ph_cnt = s.ph_cnt + 1'b1;
					if (s.ph_cnt >= WMAX_C) begin
						next_s.wst = CMW_W_IDLE;
					end
				end else begin
					next_s.ph_cnt = '0;
					next_s.wst = ph_ok ? CMW_W_REC : CMW_W_IDLE;
				end
			end
			CMW_W_REC: begin
				if (!bus_dom) begin
					next_s.ph_cnt = s.ph_cnt + 1'b1;
					if (s.ph_cnt >= WMAX_C) begin
						next_s.wst = CMW_W_IDLE;
					end
				end else begin
					next_s.ph_cnt = '0;
					// a short gap may still open a fresh pattern
					next_s.wst = ph_ok ? CMW_W_DOM2 : CMW_W_DOM1;
				end
			end
			CMW_W_DOM2: begin
				if (bus_dom) begin
					next_s.ph_cnt = s.ph_cnt + 1'b1;
					if (s.ph_cnt >= WMAX_C) begin
						next_s.wst = CMW_W_IDLE;
					end
				end else begin
					next_s.ph_cnt = '0;
					next_s.wst = CMW_W_IDLE;
					wake_evt = ph_ok;
				end
			end
			default: next_s.wst = CMW_W_IDLE;
		endcase
		if (s.mode != CMW_WAKE || !s.armed) begin
			next_s.wst = CMW_W_IDLE;
			wake_evt = 1'b0;
		end

		// clears first so a same-cycle event wins
		if (lk.clr_wake) begin
			next_s.wake_flag = 1'b0;
		end
		if (lk.clr_fail) begin
			next_s.fail_flag = 1'b0;
		end
		if (lk.clr_int) begin
			next_s.int_pend = 1'b0;
		end
		if (next_s.to_act && !s.to_act) begin
			next_s.fail_flag = 1'b1;
		end
		if (wake_evt) begin
			next_s.woke = 1'b1;
			next_s.armed = 1'b0;
			next_s.wake_flag = 1'b1;
			case (chip_mode)
				CMW_CHIP_NORMAL: next_s.int_pend = 1'b1;
				CMW_CHIP_STOP: begin
					next_s.int_pend = 1'b1;
					next_s.wdog_req = lk.wdog_on_bus_wake;
				end
				CMW_CHIP_SLEEP: next_s.restart_req = 1'b1;
				CMW_CHIP_RESTART, CMW_CHIP_FAILSAFE: next_s.restart_req = 1'b1;
				default: next_s.int_pend = s.int_pend;
			endcase
		end

		case (next_s.mode)
			CMW_NORMAL, CMW_RXONLY: next_s.rx_out = s.rx_sync[1];
			CMW_WAKE: next_s.rx_out = ~next_s.woke;
			default: next_s.rx_out = 1'b1;
		endcase
		// no driver without supply, in receive-only or during time-out
		next_s.drive = (next_s.mode == CMW_NORMAL) && next_s.tx_ok && !next_s.to_act &&
			lk.transceiver_supply && !lk.tx_data_in;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= RST;
		end else begin
			s <= next_s;
		end
	end

	assign lk.rx_data_out = s.rx_out;
	assign lk.mode_now = s.mode;
	assign lk.bus_wake_flag = s.wake_flag;
	assign lk.bus_fail_flag = s.fail_flag;
	assign lk.int_n = ~s.int_pend;
	assign bus_dom_drive = s.drive;
	assign chip_restart_req = s.restart_req;
	assign wdog_enable_req = s.wdog_req;
endmodule : cmw_xcvr_ctrl
`default_nettype wire

// file: tb/cmw_sva.sv
// cmw_sva: checks on the link between the two ends.
// assumes it sits beside the link interface, fed from tb.
`timescale 1ns/1ns
`default_nettype none
module cmw_sva
	import cmw_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// link
	input wire logic tx_data_in,
	input wire logic rx_data_out,
	input wire cmw_mode_e mode_req,
	input wire logic mode_wr,
	input wire cmw_mode_e mode_now,
	input wire logic transceiver_supply,
	input wire logic bus_wake_flag,
	input wire logic int_n,
	// chip
	input wire cmw_chip_e chip_mode
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_reset_off: assert property ($rose(presetn) |-> mode_now == CMW_OFF && int_n)
		else $error("not off after reset");
	a_off_deaf: assert property (mode_now == CMW_OFF |=> !$rose(bus_wake_flag))
		else $error("wake seen in off");
	a_normal_gate: assert property (mode_wr && mode_req == CMW_NORMAL
		&& chip_mode != CMW_CHIP_NORMAL && mode_now != CMW_NORMAL |=> mode_now != CMW_NORMAL)
		else $error("normal taken outside chip normal");
	a_tx_hold: assert property (mode_wr && mode_req == CMW_NORMAL
		&& chip_mode == CMW_CHIP_NORMAL |=> tx_data_in [*8])
		else $error("transmit not held recessive");
	a_failsafe_wake: assert property (chip_mode == CMW_CHIP_FAILSAFE
		|-> ##[0:2] mode_now == CMW_WAKE)
		else $error("fail-safe did not force wake mode");
	a_wake_rx_low: assert property ($rose(bus_wake_flag)
		|-> (!rx_data_out && mode_now == CMW_WAKE) [*8])
		else $error("receive not held low after wake");
	a_wake_irq: assert property ($rose(bus_wake_flag)
		&& chip_mode inside {CMW_CHIP_NORMAL, CMW_CHIP_STOP} |-> ##[0:1] !int_n)
		else $error("no interrupt on wake");
	a_sleep_quiet: assert property ($rose(bus_wake_flag)
		&& chip_mode == CMW_CHIP_SLEEP |=> int_n)
		else $error("interrupt on sleep wake");
	a_supply_wake: assert property (mode_now == CMW_WAKE |-> !transceiver_supply)
		else $error("supply on in wake mode");
endmodule : cmw_sva
`default_nettype wire

// file: tb/tb.sv
// tb: both ends joined over the link; apb and pins driven here.
// assumes the rtl files and the checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb;
	import cmw_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic ctl_tx = 1'b1, bus_rx_pin = 1'b1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, ctl_rx, bus_dom_drive, chip_restart_req, wdog_enable_req;
	cmw_chip_e chip_mode = CMW_CHIP_NORMAL;
	int n_errors = 0, tests_run = 0, n_rst = 0, n_wd = 0;
	cmw_link_if lk ();
	always #5 pclk = ~pclk;
	// pulses last one cycle, so count them as they pass
	always @(posedge pclk) begin
		n_rst += int'(chip_restart_req === 1'b1);
		n_wd += int'(wdog_enable_req === 1'b1);
	end
	cmw_xcvr_ctrl #(.WAKE_MAX_P(400), .TXTO_P(300)) cmw_xcvr_ctrl_i (.pclk(pclk),
		.presetn(presetn), .lk(lk), .bus_rx_pin(bus_rx_pin), .bus_dom_drive(bus_dom_drive),
		.chip_mode(chip_mode), .chip_restart_req(chip_restart_req),
		.wdog_enable_req(wdog_enable_req));
	cmw_host_ctrl cmw_host_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ctl_tx(ctl_tx), .ctl_rx(ctl_rx), .lk(lk));
	cmw_sva cmw_sva_i (.pclk(pclk), .presetn(presetn), .tx_data_in(lk.tx_data_in),
		.rx_data_out(lk.rx_data_out), .mode_req(lk.mode_req), .mode_wr(lk.mode_wr),
		.mode_now(lk.mode_now), .transceiver_supply(lk.transceiver_supply),
		.bus_wake_flag(lk.bus_wake_flag), .int_n(lk.int_n), .chip_mode(chip_mode));
	task automatic wrap_up();
		if (n_errors == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic chkb(input logic g, input logic e);
		chk({31'h0, g}, {31'h0, e});
	endtask : chkb
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc
	// entered just after a rising edge; request held until pready is seen
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && i < 20) begin
			i++;
			@(posedge pclk);
		end
		if (pready !== 1'b1) begin
			n_errors++;
			wrap_up();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic e);
		logic [31:0] r;
		logic x;
		apb(1'b1, a, {24'h00_0000, d}, r, x);
		chkb(x, e);
	endtask : wr
	task automatic rdc(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [31:0] r;
		logic x;
		apb(1'b0, a, 32'h0000_0000, r, x);
		chk(r & {24'h00_0000, m}, {24'h00_0000, e});
	endtask : rdc
	task automatic setm(input logic [7:0] c);
		wr(REG_CTRL, c, 1'b0);
		wr(REG_CMD, 8'h01, 1'b0);
	endtask : setm
	// dominant, recessive, dominant of l cycles each, then a long idle
	task automatic pat(input int l);
		bus_rx_pin <= 1'b0;
		cyc(l);
		bus_rx_pin <= 1'b1;
		cyc(l);
		bus_rx_pin <= 1'b0;
		cyc(l);
		bus_rx_pin <= 1'b1;
		cyc(500);
	endtask : pat
	task automatic t_reset();
		rdc(REG_STATUS, 8'h7F, 8'h30);
		rdc(REG_CTRL, 8'hFF, 8'h00);
		wr(12'h00C, 8'h01, 1'b1);
	endtask : t_reset
	task automatic t_normal();
		wr(REG_CTRL, 8'h03, 1'b0);
		wr(REG_CMD, 8'h01, 1'b1);
		rdc(REG_STATUS, 8'h0C, 8'h00);
		ctl_tx <= 1'b0;
		setm(8'h0B);
		cyc(1900);
		chkb(bus_dom_drive, 1'b0);
		ctl_tx <= 1'b1;
		cyc(200);
		ctl_tx <= 1'b0;
		cyc(3);
		chkb(bus_dom_drive, 1'b1);
		ctl_tx <= 1'b1;
		cyc(3);
		chkb(bus_dom_drive, 1'b0);
		rdc(REG_STATUS, 8'h4C, 8'h4C);
		bus_rx_pin <= 1'b0;
		cyc(6);
		chkb(ctl_rx, 1'b0);
		bus_rx_pin <= 1'b1;
		cyc(6);
		chkb(ctl_rx, 1'b1);
	endtask : t_normal
	task automatic t_timeout();
		ctl_tx <= 1'b0;
		cyc(200);
		chkb(bus_dom_drive, 1'b1);
		cyc(150);
		chkb(bus_dom_drive, 1'b0);
		rdc(REG_STATUS, 8'h0E, 8'h0E);
		ctl_tx <= 1'b1;
		cyc(3);
		ctl_tx <= 1'b0;
		cyc(3);
		chkb(bus_dom_drive, 1'b1);
		ctl_tx <= 1'b1;
		wr(REG_CMD, 8'h04, 1'b0);
		rdc(REG_STATUS, 8'h02, 8'h00);
	endtask : t_timeout
	task automatic t_rxonly();
		setm(8'h0A);
		ctl_tx <= 1'b0;
		cyc(5);
		chkb(bus_dom_drive, 1'b0);
		ctl_tx <= 1'b1;
		chip_mode <= CMW_CHIP_STOP;
		setm(8'h0B);
		rdc(REG_STATUS, 8'h0C, 8'h08);
		setm(8'h00);
		chip_mode <= CMW_CHIP_NORMAL;
	endtask : t_rxonly
	task automatic t_filter();
		pat(100);
		rdc(REG_STATUS, 8'h01, 8'h00);
		setm(8'h01);
		pat(50);
		pat(450);
		rdc(REG_STATUS, 8'h01, 8'h00);
		pat(51);
		rdc(REG_STATUS, 8'h11, 8'h01);
		wr(REG_CMD, 8'h0A, 1'b0);
	endtask : t_filter
	task automatic t_wake(input cmw_chip_e c, input logic [7:0] e, input logic r, input logic w);
		int r0;
		int w0;
		setm(8'h00);
		setm(8'h05);
		chip_mode <= c;
		r0 = n_rst;
		w0 = n_wd;
		pat(100);
		rdc(REG_STATUS, 8'h7D, e);
		chkb(n_rst != r0, r);
		chkb(n_wd != w0, w);
		wr(REG_CMD, 8'h0A, 1'b0);
	endtask : t_wake
	task automatic t_rearm();
		chip_mode <= CMW_CHIP_NORMAL;
		cyc(2);
		pat(100);
		rdc(REG_STATUS, 8'h21, 8'h20);
		chip_mode <= CMW_CHIP_STOP;
		cyc(2);
		pat(100);
		rdc(REG_STATUS, 8'h01, 8'h01);
		wr(REG_CMD, 8'h0A, 1'b0);
		setm(8'h00);
		chip_mode <= CMW_CHIP_FAILSAFE;
		cyc(3);
		rdc(REG_STATUS, 8'h0C, 8'h04);
	endtask : t_rearm
	initial begin
		cyc(2);
		presetn <= 1'b1;
		cyc(1);
		t_reset();
		t_normal();
		t_timeout();
		t_rxonly();
		t_filter();
		t_wake(CMW_CHIP_NORMAL, 8'h05, 1'b0, 1'b0);
		t_wake(CMW_CHIP_STOP, 8'h05, 1'b0, 1'b1);
		t_wake(CMW_CHIP_SLEEP, 8'h25, 1'b1, 1'b0);
		t_wake(CMW_CHIP_RESTART, 8'h25, 1'b1, 1'b0);
		t_wake(CMW_CHIP_FAILSAFE, 8'h25, 1'b1, 1'b0);
		t_rearm();
		wrap_up();
	end
endmodule : tb
`default_nettype wire
